// ==== logic/power_mode_sequencer.v ====
// Operating-mode sequencer: full-on, active, sleep, deep sleep and hibernate.
// Assumes software on APB, wake inputs from pins synchronised here, and that
// the reset pin and a hibernate wake both arrive as level inputs.
// Wake levels shorter than one clock may be missed by the synchronisers.
//
// What this block does
// - Active: PLL bypassed, on unless disable bit set, clocks at input
// - Multiplier change in active waits for full-on
// - Active mode allows DMA to level-one memory
// - Sleep stops core clock, PLL and system run
// - Sleep wake goes by bypass bit
// - Sleep blocks system DMA to level-one memory
// - Deep sleep stops both clocks, PLL off
// - Deep sleep blocks asynchronous peripheral access
// - Deep sleep exit only reset or RTC
// - Reset in deep sleep goes to full-on
// - Frequency field zero enters hibernate, supply off
// - Hibernate puts pins in high impedance
// - Hibernate wake by Ethernet, CAN, pin, RTC, reset
// - Each hibernate wake source but reset pin has enable bit
// - Every hibernate wake runs full reset sequence
// - Only regulator control survives hibernate
// - Hold bit keeps SDRAM clock enable low after hibernate until cleared
// - Regulator level steps of 50 mV
// - Power-up in full-on, PLL on, not bypassed
`timescale 1ns/1ps
`include "power_mode_defs.vh"

module power_mode_sequencer
(
   input wire pclk,                // APB clock, 20 MHz
   input wire presetn,             // Power-on reset, active low
   input wire [11:0] paddr,        // APB address
   input wire psel,                // APB select
   input wire penable,             // APB enable
   input wire pwrite,              // APB direction
   input wire [31:0] pwdata,       // APB write data
   output reg [31:0] prdata,       // APB read data
   output reg pready,              // APB ready
   output reg pslverr,             // APB error
   input wire reset_pin_n,         // Reset pin, active low, async
   input wire rtc_wake,            // RTC wake / interrupt, async
   input wire eth_wake,            // Ethernet wake, async
   input wire can_wake,            // CAN wake, async
   input wire port_h_pin_six,      // PHY interrupt input, wake when low
   input wire sdram_cke_req,       // SDRAM clock enable from controller
   output reg core_clock_en,       // Core clock gate
   output reg system_clock_en,     // System clock gate
   output reg pll_enable,          // PLL powered
   output reg pll_bypass,          // PLL bypassed
   output reg [5:0] pll_mult,      // Multiplier in effect
   output reg supply_on,           // Internal supply on
   output reg [3:0] supply_level,  // Regulator level, 50 mV steps
   output reg l1_dma_allow,        // DMA into level-one memory allowed
   output reg async_access_allow,  // Async peripherals may reach internals
   output reg pins_drive_en,       // Low in hibernate: pins float
   output reg hw_reset_n,          // Full hardware reset sequence, low active
   output reg sdram_clock_enable_pin // SDRAM clock enable
);

   reg [31:0] pll_control_register;
   reg [31:0] regulator_control_register;
   reg [2:0] mode;
   reg [2:0] next_mode;
   reg [5:0] mult_applied;
   reg cke_hold;
   reg [4:0] sync1;
   reg [4:0] sync2;
   reg rst_seen;
   reg [1:0] cmd;
   reg cmd_valid;
   reg hib_write;

   wire wr = psel & penable & pwrite;
   wire rd = psel & penable & ~pwrite;
   wire s_reset = ~sync2[0];
   wire s_rtc = sync2[1];
   wire s_eth = sync2[2];
   wire s_can = sync2[3];
   wire s_pin_six_low = ~sync2[4];
   wire bypass = pll_control_register[`PLL_BYPASS_BIT];
   wire pll_off = pll_control_register[`PLL_DISABLE_BIT];
   // Sleep leaves on every synchronised wake input
   wire any_wake = s_reset | s_rtc | s_eth | s_can | s_pin_six_low;

   // Unmapped offsets answer with an error and read as zero
   function mapped;
      input [11:0] a;
      begin
         mapped = (a == `PLL_CONTROL_ADDR) || (a == `REGULATOR_ADDR) ||
                  (a == `MODE_CMD_ADDR) || (a == `STATUS_ADDR);
      end
   endfunction

   // Access-phase write aimed at one register
   function write_hit;
      input strobe;
      input [11:0] a;
      input [11:0] target;
      begin
         write_hit = strobe && (a == target);
      end
   endfunction

   // Pins cross into pclk through two flops each
   // Reset values match the idle pin levels, so no false wake follows reset
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync1 <= 5'h11;
         sync2 <= 5'h11;
      end
      else
      begin
         sync1 <= {port_h_pin_six, can_wake, eth_wake, rtc_wake, reset_pin_n};
         sync2 <= sync1;
      end
   end

   // Hibernate wake: any enabled source, or the reset pin
   // wake source set
   wire hib_wake = s_reset |
      (s_eth & regulator_control_register[`VR_WAKE_ETH_BIT]) |
      (s_can & regulator_control_register[`VR_WAKE_CAN_BIT]) |
      (s_pin_six_low & regulator_control_register[`VR_WAKE_PIN6_BIT]) |
      (s_rtc & regulator_control_register[`VR_WAKE_RTC_BIT]);

   always @*
   begin
      next_mode = mode;
      case (mode)
         `MODE_FULL_ON, `MODE_ACTIVE:
         begin
            if (hib_write)
               next_mode = `MODE_HIBERNATE;
            else if (cmd_valid && cmd == `CMD_SLEEP)
               next_mode = `MODE_SLEEP;
            else if (cmd_valid && cmd == `CMD_DEEP_SLEEP)
               next_mode = `MODE_DEEP_SLEEP;
            else if (mode == `MODE_FULL_ON && bypass)
               next_mode = `MODE_ACTIVE;
            else if (mode == `MODE_ACTIVE && !bypass && !pll_off)
               next_mode = `MODE_FULL_ON;
         end
         `MODE_SLEEP:
         begin
            if (any_wake)
               next_mode = bypass ? `MODE_ACTIVE : `MODE_FULL_ON;
         end
         `MODE_DEEP_SLEEP:
         begin
            if (s_reset)
               next_mode = `MODE_FULL_ON;
            else if (s_rtc)
               next_mode = `MODE_ACTIVE;
         end
         `MODE_HIBERNATE:
         begin
            if (hib_wake)
               next_mode = `MODE_FULL_ON;
         end
         default:
            next_mode = `MODE_FULL_ON;
      endcase
   end

   // Mode register and pending-command latch
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mode <= `MODE_FULL_ON;
         hib_write <= 1'b0;
         mult_applied <= `PLL_MULT_RESET;
         rst_seen <= 1'b0;
      end
      else
      begin
         mode <= next_mode;
         hib_write <= write_hit(wr, paddr, `REGULATOR_ADDR) &&
                      pwdata[`VR_RATE_MSB:`VR_RATE_LSB] == `VR_RATE_HIBERNATE;
         // multiplier applies in full-on only
         // Held multiplier is loaded on every edge where next mode is full-on
         if (next_mode == `MODE_FULL_ON)
            mult_applied <= pll_control_register[`PLL_MULT_MSB:`PLL_MULT_LSB];
         // One-cycle pulse: set on the same edge that mode leaves hibernate
         rst_seen <= mode == `MODE_HIBERNATE && hib_wake;
      end
   end

   // Mode command is latched for one cycle, then acted on by the mode decode
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cmd <= 2'h0;
         cmd_valid <= 1'b0;
      end
      else
      begin
         cmd_valid <= write_hit(wr, paddr, `MODE_CMD_ADDR);
         cmd <= pwdata[1:0];
      end
   end

   // Registers; a hibernate wake clears all but the regulator control
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pll_control_register <= `PLL_CONTROL_RESET;
         regulator_control_register <= `REGULATOR_RESET;
         cke_hold <= 1'b0;
      end
      else
      begin
         if (rst_seen)
            pll_control_register <= `PLL_CONTROL_RESET;
         // an RTC wake lands in active, so bypass must read set
         else if (mode == `MODE_DEEP_SLEEP && next_mode == `MODE_ACTIVE)
            pll_control_register[`PLL_BYPASS_BIT] <= 1'b1;
         // Writes while hibernating are dropped: the core is unpowered
         else if (write_hit(wr, paddr, `PLL_CONTROL_ADDR) && mode != `MODE_HIBERNATE)
            pll_control_register <= pwdata;
         if (write_hit(wr, paddr, `REGULATOR_ADDR) && mode != `MODE_HIBERNATE)
            regulator_control_register <= pwdata;
         // hold low through wake until software clears the bit
         if (mode == `MODE_HIBERNATE)
            cke_hold <= regulator_control_register[`VR_CKE_HOLD_BIT];
         else if (!regulator_control_register[`VR_CKE_HOLD_BIT])
            cke_hold <= 1'b0;
      end
   end

   // APB answer: zero wait, unmapped address flags an error
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped(paddr);
         prdata <= 32'h00000000;
         // Read data is latched in setup so it stands through the access cycle
         if (psel && !penable && !pwrite)
         begin
            case (paddr)
               `PLL_CONTROL_ADDR: prdata <= pll_control_register;
               `REGULATOR_ADDR: prdata <= regulator_control_register;
               `STATUS_ADDR: prdata <= {22'h000000, mult_applied, cke_hold, mode};
               default: prdata <= 32'h00000000;
            endcase
         end
      end
   end

   // Clock, PLL, supply and pin controls, all registered
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         core_clock_en <= 1'b1;
         system_clock_en <= 1'b1;
         pll_enable <= 1'b1;
         pll_bypass <= 1'b0;
         pll_mult <= `PLL_MULT_RESET;
         supply_on <= 1'b1;
         supply_level <= 4'hb;
         l1_dma_allow <= 1'b1;
         async_access_allow <= 1'b1;
         pins_drive_en <= 1'b1;
         hw_reset_n <= 1'b1;
         sdram_clock_enable_pin <= 1'b0;
      end
      else
      begin
         // level field, one step per 50 mV
         supply_level <= regulator_control_register[`VR_LEVEL_MSB:`VR_LEVEL_LSB];
         pll_mult <= mult_applied;
         hw_reset_n <= ~rst_seen;
         // Outputs follow next_mode so they change on the same edge as mode
         case (next_mode)
            `MODE_ACTIVE:
            begin
               core_clock_en <= 1'b1;
               system_clock_en <= 1'b1;
               pll_enable <= ~pll_off;
               pll_bypass <= 1'b1;
               supply_on <= 1'b1;
               l1_dma_allow <= 1'b1;
               async_access_allow <= 1'b1;
               pins_drive_en <= 1'b1;
            end
            `MODE_SLEEP:
            begin
               core_clock_en <= 1'b0;
               system_clock_en <= 1'b1;
               pll_enable <= 1'b1;
               pll_bypass <= bypass;
               supply_on <= 1'b1;
               l1_dma_allow <= 1'b0;
               async_access_allow <= 1'b1;
               pins_drive_en <= 1'b1;
            end
            `MODE_DEEP_SLEEP:
            begin
               core_clock_en <= 1'b0;
               system_clock_en <= 1'b0;
               pll_enable <= 1'b0;
               pll_bypass <= bypass;
               supply_on <= 1'b1;
               l1_dma_allow <= 1'b0;
               async_access_allow <= 1'b0;
               pins_drive_en <= 1'b1;
            end
            `MODE_HIBERNATE:
            begin
               core_clock_en <= 1'b0;
               system_clock_en <= 1'b0;
               pll_enable <= 1'b0;
               pll_bypass <= bypass;
               supply_on <= 1'b0;
               l1_dma_allow <= 1'b0;
               async_access_allow <= 1'b0;
               pins_drive_en <= 1'b0;
            end
            default:
            begin
               core_clock_en <= 1'b1;
               system_clock_en <= 1'b1;
               pll_enable <= 1'b1;
               pll_bypass <= 1'b0;
               supply_on <= 1'b1;
               l1_dma_allow <= 1'b1;
               async_access_allow <= 1'b1;
               pins_drive_en <= 1'b1;
            end
         endcase
         // held low; external pulldown covers the unpowered span
         sdram_clock_enable_pin <= sdram_cke_req & ~cke_hold &
                                   (next_mode != `MODE_HIBERNATE);
      end
   end

endmodule // power_mode_sequencer

// ==== logic/power_mode_defs.vh ====
// Register offsets, field positions, reset values and mode codes of the mode sequencer.
// Assumes a 32-bit APB register bus with one aligned word per register.
`ifndef POWER_MODE_DEFS_VH
`define POWER_MODE_DEFS_VH

// Register byte offsets
`define PLL_CONTROL_ADDR 12'h000
`define REGULATOR_ADDR 12'h004
`define MODE_CMD_ADDR 12'h008
`define STATUS_ADDR 12'h00c

// PLL control fields
`define PLL_DISABLE_BIT 0
`define PLL_BYPASS_BIT 1
`define PLL_MULT_LSB 9
`define PLL_MULT_MSB 14
`define PLL_MULT_RESET 6'h0a
`define PLL_CONTROL_RESET 32'h00001400

// Regulator control fields
`define VR_RATE_LSB 0
`define VR_RATE_MSB 1
`define VR_RATE_HIBERNATE 2'h0
`define VR_LEVEL_LSB 4
`define VR_LEVEL_MSB 7
`define VR_WAKE_ETH_BIT 8
`define VR_WAKE_CAN_BIT 9
`define VR_WAKE_PIN6_BIT 10
`define VR_WAKE_RTC_BIT 11
`define VR_CKE_HOLD_BIT 12
`define REGULATOR_RESET 32'h000000b3
`define VR_STEP_MV 50

// Mode command codes, written to the mode command register
`define CMD_SLEEP 2'h1
`define CMD_DEEP_SLEEP 2'h2

// Operating mode codes
`define MODE_FULL_ON 3'h0
`define MODE_ACTIVE 3'h1
`define MODE_SLEEP 3'h2
`define MODE_DEEP_SLEEP 3'h3
`define MODE_HIBERNATE 3'h4

`endif

// ==== test/power_mode_checker.sv ====
// Port checks for the mode sequencer.
// Assumes a bind onto the sequencer; one clock domain.
`timescale 1ns/1ps
module power_mode_checker
(
   input wire pclk,               // Clock
   input wire presetn,            // Reset, low
   input wire psel,               // APB
   input wire penable,            // APB
   input wire pready,             // APB
   input wire rtc_wake,           // Wake
   input wire can_wake,           // Wake
   input wire core_clock_en,      // Gate
   input wire system_clock_en,    // Gate
   input wire pll_enable,         // PLL
   input wire pll_bypass,         // PLL
   input wire [5:0] pll_mult,     // PLL
   input wire supply_on,          // Supply
   input wire l1_dma_allow,       // DMA
   input wire async_access_allow, // Async
   input wire pins_drive_en,      // Pins
   input wire hw_reset_n          // Reset out
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_sleep_clocks: assert property (
      !core_clock_en && system_clock_en |-> pll_enable && !l1_dma_allow)
      else $error("sleep outputs wrong");
   a_deep_clocks: assert property (
      supply_on && !system_clock_en |-> !core_clock_en && !pll_enable && !async_access_allow)
      else $error("deep sleep outputs wrong");
   a_hib_off: assert property (
      !supply_on |-> !system_clock_en && !core_clock_en && !pins_drive_en)
      else $error("hibernate outputs wrong");
   a_active_dma: assert property (
      pll_bypass && core_clock_en |-> system_clock_en && l1_dma_allow)
      else $error("active outputs wrong");
   a_mult_pending: assert property (
      $changed(pll_mult) |-> !pll_bypass)
      else $error("multiplier moved while bypassed");
   a_wake_reset: assert property (
      $rose(supply_on) |-> ##[1:2] !hw_reset_n)
      else $error("no reset after wake");
   a_reset_pulse: assert property (
      !hw_reset_n |=> hw_reset_n)
      else $error("reset pulse too long");
   a_sleep_wake: assert property (
      !core_clock_en && system_clock_en && $rose(can_wake) |-> ##[1:4] core_clock_en)
      else $error("sleep did not wake");
   a_rtc_active: assert property (
      supply_on && !system_clock_en && $rose(rtc_wake) |-> ##[1:4] pll_bypass && core_clock_en)
      else $error("deep sleep did not reach active");
   a_apb_answer: assert property (
      psel && !penable |=> pready)
      else $error("no ready after setup");
endmodule // power_mode_checker

bind power_mode_sequencer power_mode_checker power_mode_checker_inst (.pclk, .presetn,
   .psel, .penable, .pready, .rtc_wake, .can_wake, .core_clock_en, .system_clock_en,
   .pll_enable, .pll_bypass, .pll_mult, .supply_on, .l1_dma_allow, .async_access_allow,
   .pins_drive_en, .hw_reset_n);

// ==== test/wake_source_model.sv ====
// Far side: reset pin, wake sources, SDRAM controller.
// Assumes fire is a one-cycle pulse with a source code.
`timescale 1ns/1ps
module wake_source_model
(
   input wire pclk,            // Clock
   input wire fire,            // Start event
   input wire [2:0] src,       // 0 eth 1 can 2 pin 3 rtc 4 reset
   output wire reset_pin_n,    // Low active
   output wire rtc_wake,       // Wake
   output wire eth_wake,       // Wake
   output wire can_wake,       // Wake
   output wire port_h_pin_six, // Pulled up, low wakes
   output wire sdram_cke_req   // Self-refresh keeps asking
);
   reg [2:0] cnt = 3'h0;
   reg [2:0] held = 3'h0;
   wire on = cnt != 3'h0;
   // Four cycles so the two-flop synchronisers always catch it
   always @(posedge pclk)
   begin
      if (fire)
      begin
         cnt <= 3'h4;
         held <= src;
      end
      else if (on)
         cnt <= cnt - 3'h1;
   end
   assign eth_wake = on && held == 3'h0;
   assign can_wake = on && held == 3'h1;
   assign port_h_pin_six = !(on && held == 3'h2);
   assign rtc_wake = on && held == 3'h3;
   assign reset_pin_n = !(on && held == 3'h4);
   assign sdram_cke_req = 1'b1;
endmodule // wake_source_model

// ==== test/power_mode_sequencer_tb_top.sv ====
// Bench for the mode sequencer over APB.
// Assumes the checker and wake model are compiled first.
`timescale 1ns/1ps
module power_mode_sequencer_tb_top;
   reg pclk = 0;
   reg presetn = 0;
   reg [11:0] paddr = 0;
   reg psel = 0;
   reg penable = 0;
   reg pwrite = 0;
   reg [31:0] pwdata = 0;
   reg fire = 0;
   reg [2:0] src = 0;
   wire [31:0] prdata;
   wire pready, pslverr, reset_pin_n, rtc_wake, eth_wake, can_wake, port_h_pin_six;
   wire sdram_cke_req, core_clock_en, system_clock_en, pll_enable, pll_bypass, supply_on;
   wire l1_dma_allow, async_access_allow, pins_drive_en, hw_reset_n, sdram_clock_enable_pin;
   wire [5:0] pll_mult;
   wire [3:0] supply_level;
   integer n_mismatch = 0;
   integer n_tests = 0;
   integer i;
   reg [31:0] rd;
   reg err;
   always #25 pclk = ~pclk;
   power_mode_sequencer power_mode_sequencer_inst (.pclk, .presetn, .paddr, .psel,
      .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .reset_pin_n, .rtc_wake,
      .eth_wake, .can_wake, .port_h_pin_six, .sdram_cke_req, .core_clock_en,
      .system_clock_en, .pll_enable, .pll_bypass, .pll_mult, .supply_on, .supply_level,
      .l1_dma_allow, .async_access_allow, .pins_drive_en, .hw_reset_n,
      .sdram_clock_enable_pin);
   wake_source_model wake_source_model_inst (.pclk, .fire, .src, .reset_pin_n,
      .rtc_wake, .eth_wake, .can_wake, .port_h_pin_six, .sdram_cke_req);
   task xfer(input w, input [11:0] a, input [31:0] d);
   begin
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
   begin
      n_tests = n_tests + 1;
      if (got !== exp)
      begin
         n_mismatch = n_mismatch + 1;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   end
   endtask
   task settle;
      repeat (6) @(posedge pclk);
   endtask
   task wake(input [2:0] s);
   begin
      @(posedge pclk);
      src <= s;
      fire <= 1;
      @(posedge pclk);
      fire <= 0;
      repeat (8) @(posedge pclk);
   end
   endtask
   task mode(input [2:0] m);
   begin
      xfer(0, 12'h00c, 0);
      chk({29'h0, rd[2:0]}, {29'h0, m});
   end
   endtask
   task complete_run;
   begin
      $display("mismatches %0d of %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   end
   endtask
   initial
   begin
      repeat (20000) @(posedge pclk);
      n_mismatch = n_mismatch + 1;
      complete_run;
   end
   initial
   begin
      repeat (20) @(posedge pclk);
      presetn <= 1;
      xfer(0, 12'h000, 0);
      chk(rd, 32'h00001400);
      chk({31'h0, pll_enable & ~pll_bypass}, 1);
      xfer(0, 12'h010, 0);
      chk({31'h0, err}, 1);
      xfer(1, 12'h000, 32'h00001402);
      settle;
      mode(3'h1);
      xfer(1, 12'h000, 32'h00001803);
      settle;
      chk({26'h0, pll_mult}, 32'h0a);
      chk({31'h0, pll_enable}, 0);
      xfer(1, 12'h000, 32'h00001802);
      xfer(1, 12'h000, 32'h00001800);
      settle;
      chk({26'h0, pll_mult}, 32'h0c);
      mode(3'h0);
      for (i = 0; i < 2; i = i + 1)
      begin
         xfer(1, 12'h000, {30'h600, i[0], 1'b0});
         xfer(1, 12'h008, 1);
         settle;
         chk({29'h0, core_clock_en, system_clock_en, l1_dma_allow}, 2);
         wake(1);
         mode({2'h0, i[0]});
      end
      xfer(1, 12'h000, 32'h00001800);
      xfer(1, 12'h008, 2);
      settle;
      chk({29'h0, system_clock_en, pll_enable, async_access_allow}, 0);
      wake(0);
      mode(3'h3);
      wake(3);
      mode(3'h1);
      xfer(1, 12'h000, 32'h00001800);
      xfer(1, 12'h008, 2);
      settle;
      wake(4);
      mode(3'h0);
      for (i = 0; i < 5; i = i + 1)
      begin
         xfer(1, 12'h004, 32'h000010b0 | ((32'h100 << i) & 32'h00000f00));
         settle;
         chk({30'h0, supply_on, pins_drive_en}, 0);
         wake({1'b0, i[1:0] + 2'h1});
         chk({31'h0, supply_on}, 0);
         wake(i[2:0]);
         chk({30'h0, supply_on, sdram_clock_enable_pin}, 2);
         xfer(0, 12'h000, 0);
         chk(rd, 32'h00001400);
      end
      xfer(0, 12'h004, 0);
      chk(rd, 32'h000010b0);
      xfer(1, 12'h004, 32'h00000053);
      settle;
      chk({27'h0, supply_level, sdram_clock_enable_pin}, 32'h0b);
      complete_run;
   end
endmodule // power_mode_sequencer_tb_top
